//--- logic/drc_refresh_ctrl.sv
`timescale 1ns/1ps
module drc_refresh_ctrl #(
  parameter int unsigned RFC_CYC    = drc_pkg::RFC_CYC,
  parameter int unsigned XSNR_CYC   = drc_pkg::XSNR_CYC,
  parameter int unsigned RELOCK_CYC = drc_pkg::RELOCK_CYC,
  parameter int unsigned REFI_CYC   = drc_pkg::REFI_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic                          cke,
  input  wire logic                          cs_n,
  input  wire logic                          ras_n,
  input  wire logic                          cas_n,
  input  wire logic                          we_n,
  output logic                               busy_q,
  output logic                               self_refresh_q,
  output logic                               dll_on_q,
  output logic                               read_ok_q,
  output logic                               row_strobe_q,
  output logic [drc_pkg::ROW_BITS-1:0]       row_addr_q,
  output logic                               illegal_cmd_q
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage read only by the second
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 5'h0F;
      s2_q <= 5'h0F;
    end else begin
      s1_q <= {cke, cs_n, ras_n, cas_n, we_n};
      s2_q <= s1_q;
    end
  end

  logic       cke_s;
  logic [3:0] cmd_s;
  logic       is_ref;
  logic       is_nop;
  assign cke_s  = s2_q[4];
  assign cmd_s  = s2_q[3:0];
  assign is_ref = cmd_s == drc_pkg::DRC_CMD_REF;
  assign is_nop = cmd_s == drc_pkg::DRC_CMD_NOP || cmd_s[3];

  ////////////////////////////////////////////////////////////////////////////
  localparam int CW = 16;
  drc_pkg::drc_state_t st_q;
  drc_pkg::drc_state_t st_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] lock_q;
  logic [CW-1:0] lock_d;
  logic          step;
  logic          busy_d;
  logic          self_d;
  logic          dll_d;
  logic          ill_d;

  drc_row_counter u_rows (
    .clk    (clk),
    .arst_n (arst_n),
    .step   (step),
    .row_q  (row_addr_q)
  );

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    lock_d = (lock_q != '0) ? lock_q - CW'(1) : lock_q;
    step   = 1'b0;
    ill_d  = 1'b0;
    unique case (st_q)
      drc_pkg::DRC_IDLE: begin
        if (is_ref && cke_s) begin
          st_d  = drc_pkg::DRC_AREF;
          cnt_d = CW'(RFC_CYC);
          step  = 1'b1;
        end else if (is_ref && !cke_s) begin
          st_d   = drc_pkg::DRC_SELF;
          cnt_d  = CW'(REFI_CYC);
          step   = 1'b1;
        end
      end
      drc_pkg::DRC_AREF: begin
        // commands during the refresh period are flagged and dropped
        if (!is_nop || !cke_s) begin
          ill_d = 1'b1;
        end
        cnt_d = cnt_q - CW'(1);
        if (cnt_q == CW'(1)) begin
          st_d = drc_pkg::DRC_IDLE;
        end
      end
      drc_pkg::DRC_SELF: begin
        // own timer, counted on clk edges, keeps rows refreshed; no refresh commands needed
        cnt_d = cnt_q - CW'(1);
        if (cnt_q == CW'(1)) begin
          cnt_d = CW'(REFI_CYC);
          step  = 1'b1;
        end
        if (cke_s) begin
          st_d   = drc_pkg::DRC_EXIT;
          cnt_d  = CW'(XSNR_CYC);
          lock_d = CW'(RELOCK_CYC);
        end
      end
      drc_pkg::DRC_EXIT: begin
        if (!is_nop) begin
          ill_d = 1'b1;
        end
        cnt_d = cnt_q - CW'(1);
        if (cnt_q == CW'(1)) begin
          st_d = drc_pkg::DRC_IDLE;
        end
      end
    endcase
    busy_d = st_d != drc_pkg::DRC_IDLE;
    self_d = st_d == drc_pkg::DRC_SELF;
    dll_d  = st_d != drc_pkg::DRC_SELF;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q           <= drc_pkg::DRC_IDLE;
      cnt_q          <= '0;
      lock_q         <= '0;
      busy_q         <= 1'b0;
      self_refresh_q <= 1'b0;
      dll_on_q       <= 1'b1;
      read_ok_q      <= 1'b1;
      row_strobe_q   <= 1'b0;
      illegal_cmd_q  <= 1'b0;
    end else begin
      st_q           <= st_d;
      cnt_q          <= cnt_d;
      lock_q         <= lock_d;
      busy_q         <= busy_d;
      self_refresh_q <= self_d;
      dll_on_q       <= dll_d;
      read_ok_q      <= dll_d && lock_d == '0;
      row_strobe_q   <= step;
      illegal_cmd_q  <= ill_d;
    end
  end
endmodule

//--- logic/drc_pkg.sv
package drc_pkg;
  localparam int unsigned CLK_MHZ          = 40;
  localparam int unsigned ROW_BITS         = 13;
  // refresh cycle time and exit wait in ns; plain defaults
  localparam int unsigned T_RFC_NS         = 75;
  localparam int unsigned T_XSNR_NS        = 75;
  localparam int unsigned RFC_CYC          = (T_RFC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned XSNR_CYC         = (T_XSNR_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RELOCK_CYC       = 200;
  // self-refresh internal interval, 7.8125 us in ps
  localparam int unsigned T_REFI_PS        = 7812500;
  localparam int unsigned REFI_CYC         = (T_REFI_PS / 1000) * CLK_MHZ / 1000;
  localparam logic [ROW_BITS-1:0] ROW_RST  = 13'h0000;
  typedef enum logic [3:0] {
    DRC_CMD_NOP  = 4'h7,
    DRC_CMD_REF  = 4'h1,
    DRC_CMD_DESL = 4'h8
  } drc_cmd_t;
  typedef enum {DRC_IDLE, DRC_AREF, DRC_SELF, DRC_EXIT} drc_state_t;
endpackage

//--- logic/drc_row_counter.sv
`timescale 1ns/1ps
module drc_row_counter #(
  parameter int unsigned W = drc_pkg::ROW_BITS
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         step,
  output logic [W-1:0]      row_q
);
  logic [W-1:0] row_d;

  always_comb begin
    row_d = row_q;
    if (step) begin
      row_d = row_q + W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      row_q <= drc_pkg::ROW_RST;
    end else begin
      row_q <= row_d;
    end
  end
endmodule

//--- bench/drc_refresh_properties.sv
`timescale 1ns/1ps
module drc_refresh_props (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic        busy_q,
  input wire logic        self_refresh_q,
  input wire logic        dll_on_q,
  input wire logic        read_ok_q,
  input wire logic        row_strobe_q,
  input wire logic [12:0] row_addr_q,
  input wire logic        illegal_cmd_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // a refresh held over several edges is one request; only its first edge counts,
  // since busy_q lags the pins by three edges: the two synchroniser stages plus its own register
  sequence s_ref;
    !cs_n && !ras_n && !cas_n && we_n && !busy_q
      && $past(cs_n || ras_n || cas_n || !we_n)
      && $past(cs_n || ras_n || cas_n || !we_n, 2);
  endsequence
  a_auto_ref_start: assert property (s_ref ##0 cke |-> ##3 busy_q && row_strobe_q)
    else $error("auto refresh not started");
  a_busy_len: assert property ($rose(busy_q) && $past(cke, 3) |-> busy_q [*3] ##1 !busy_q)
    else $error("refresh period length wrong");
  a_row_step: assert property (row_strobe_q |-> row_addr_q == $past(row_addr_q) + 13'h0001)
    else $error("row counter did not step");
  a_self_entry: assert property (s_ref ##0 !cke |-> ##3 self_refresh_q)
    else $error("self refresh not entered");
  a_self_dll_off: assert property (self_refresh_q |-> !dll_on_q && !read_ok_q && busy_q)
    else $error("loop not off in self refresh");
  a_self_quiet: assert property (self_refresh_q && !$past(cke) |-> !illegal_cmd_q)
    else $error("input seen in self refresh");
  a_dll_back: assert property ($fell(self_refresh_q) |-> ##[0:2] dll_on_q)
    else $error("loop not back on after exit");
endmodule
bind drc_refresh_ctrl drc_refresh_props u_chk (.*);

//--- bench/drc_ctl_model.sv
`timescale 1ns/1ps
module drc_ctl_model (
  input  wire logic       clk,
  input  wire logic [1:0] op,
  output logic            cke,
  output logic            cs_n,
  output logic            ras_n,
  output logic            cas_n,
  output logic            we_n
);
  // op: 0 nop, 1 refresh, 2 enter self refresh, 3 stay in self refresh
  logic [3:0] junk_q = 4'h0;
  always @(posedge clk) junk_q <= junk_q + 4'h5;
  always_comb begin
    cke = (op < 2'h2);
    {cs_n, ras_n, cas_n, we_n} = (op == 2'h1 || op == 2'h2) ? 4'h1 : 4'h7;
    if (op == 2'h3) {cs_n, ras_n, cas_n, we_n} = junk_q;
  end
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [1:0] op; logic [2:0] exp;} drc_row_t;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [1:0]  op = 2'h0;
  logic        cke, cs_n, ras_n, cas_n, we_n, busy, slf, dll, rok, stb, ill;
  logic [12:0] row;
  logic [12:0] exp_row = 13'h0000;
  int          bad_count = 0;
  int          cmp_count = 0;
  drc_row_t    rows [4] = '{'{2'h0, 3'h0}, '{2'h1, 3'h6}, '{2'h1, 3'h6}, '{2'h0, 3'h0}};
  initial forever #12.5 clk = ~clk;
  drc_ctl_model u_ctl (.clk(clk), .op(op), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n));
  drc_refresh_ctrl #(.RELOCK_CYC(5), .REFI_CYC(8)) uut (.clk(clk), .arst_n(arst_n),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .busy_q(busy),
    .self_refresh_q(slf), .dll_on_q(dll), .read_ok_q(rok), .row_strobe_q(stb),
    .row_addr_q(row), .illegal_cmd_q(ill));
  task chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // leaves us just after the edge where the answer shows
  task issue(input logic [1:0] o, input logic [1:0] nx);
    @(posedge clk);
    #1 op = o;
    @(posedge clk);
    #1 op = nx;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task wrap_up;
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clk);
    chk(16'({busy, slf, dll, rok, stb, ill}), 16'h000C);
    #1 arst_n = 1'b1;
    foreach (rows[i]) begin
      issue(rows[i].op, 2'h0);
      if (rows[i].op == 2'h1) exp_row = exp_row + 13'h0001;
      chk(16'({busy, stb, slf}), 16'(rows[i].exp));
      chk(16'(row), 16'(exp_row));
      repeat (3) @(posedge clk);
    end
    // refresh held on the pins: one row step, the extra edges are flagged
    issue(2'h1, 2'h1);
    exp_row = exp_row + 13'h0001;
    op = 2'h0;
    @(posedge clk);
    #1;
    chk(16'({busy, ill}), 16'h0003);
    chk(16'(row), 16'(exp_row));
    repeat (2) @(posedge clk);
    #1;
    chk(16'({busy, ill}), 16'h0000);
    issue(2'h2, 2'h3);
    chk(16'({slf, dll, rok}), 16'h0004);
    repeat (20) @(posedge clk);
    #1;
    // one step on entry, then one every 8 cycles of the shortened interval
    exp_row = exp_row + 13'h0003;
    chk(16'({slf, ill}), 16'h0002);
    chk(16'(row), 16'(exp_row));
    op = 2'h0;
    repeat (5) @(posedge clk);
    #1;
    chk(16'(rok), 16'h0000);
    repeat (12) @(posedge clk);
    #1;
    chk(16'({slf, dll, busy, rok}), 16'h0005);
    wrap_up;
  end
endmodule
